//--- dv/t8pwm_properties.sv
`timescale 1ns/1ps
module t8pwm_properties
    import t8pwm_pkg::*;
#(
    parameter int DIV = PRESCALE_DIV
) (
    input wire logic clk_sys,
    input wire logic nrst,
    input wire logic timerRun,
    input wire t8pwm_cfg_t cfg,
    input wire logic compareWr,
    input wire logic [7:0] compareWrData,
    input wire logic compareFlagClr,
    input wire logic overflowFlagClr,
    input wire t8pwm_stat_t stat,
    input wire logic [7:0] compareBufValue,
    input wire logic timerTick,
    input wire logic compareOutput,
    input wire logic compareOutputEn
);
    logic [7:0] lastCnt_ff;
    logic matchSeen_ff;
    wire logic [7:0] cnt = stat.countValue;
    wire logic [7:0] cmpV = stat.compareValue;
    wire logic isClear = cfg.waveformModeSel == WAVE_CLEAR;
    wire logic isFast = cfg.waveformModeSel == WAVE_FAST;
    wire logic isPhase = cfg.waveformModeSel == WAVE_PHASE;
    wire logic isPwm = cfg.waveformModeSel[0];
    wire logic actLow = cfg.outputActionSel[0];
    wire logic isDown = lastCnt_ff > cnt;
    wire logic atTop = timerTick && cnt == 8'hff;
    wire logic matchTick = timerTick && matchSeen_ff;

    // Count seen at the previous tick tells the slope without peeking inside
    always_ff @(posedge clk_sys) begin
        if (!nrst) begin
            lastCnt_ff <= 8'h00;
            matchSeen_ff <= 1'b0;
        end else if (timerTick) begin
            lastCnt_ff <= cnt;
            matchSeen_ff <= cnt == cmpV;
        end
    end

    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (!nrst);

    sequence s_match;
        timerTick && cnt == cmpV;
    endsequence
    sequence s_top;
        timerTick && cnt == 8'hff;
    endsequence

    a_idle_hold: assert property (!timerTick |=> $stable(cnt) && $stable(compareOutput))
        else $error("state moved without tick");
    a_ctc_clear: assert property (isClear and s_match |=> cnt == 8'h00)
        else $error("count not cleared on match");
    a_ctc_wrap: assert property (isClear and s_top |=> cnt == 8'h00 && stat.countOverflowFlag)
        else $error("overflow missing at wrap");
    a_ctc_toggle: assert property ((isClear && cfg.outputActionSel == ACT_TOGGLE) and s_match |=> $changed(compareOutput))
        else $error("output not toggled");
    a_ctc_direct: assert property (isClear && compareWr |=> cmpV == $past(compareWrData))
        else $error("compare write not immediate");
    a_pwm_load: assert property ($changed(cmpV) && $past(isPwm) |-> $past(atTop))
        else $error("compare loaded off boundary");
    a_fast_top: assert property (isFast and s_top |=> cnt == 8'h00 && stat.countOverflowFlag)
        else $error("fast wrap wrong");
    a_fast_bottom: assert property ((isFast && cfg.outputActionSel[1]) and s_top |=> compareOutput == !$past(actLow))
        else $error("fast bottom level wrong");
    a_fast_match: assert property ((isFast && cfg.outputActionSel[1] && cmpV != 8'hff) and s_match
        |=> compareOutput == $past(actLow))
        else $error("fast match level wrong");
    a_phase_turn: assert property (isPhase && timerTick && lastCnt_ff == 8'hff |-> cnt == 8'hfe)
        else $error("top not held one tick");
    a_phase_bottom: assert property (isPhase && timerTick && cnt == 8'h01 && lastCnt_ff == 8'h02
        |=> cnt == 8'h00 && stat.countOverflowFlag)
        else $error("phase bottom overflow wrong");
    a_phase_match: assert property ((isPhase && cfg.outputActionSel[1] && cnt != 8'h00 && cnt != 8'hff) and s_match
        |=> compareOutput == ($past(actLow) ^ $past(isDown)))
        else $error("phase match level wrong");
    a_flag_set: assert property (matchTick |=> stat.compareMatchFlag)
        else $error("compare flag not set");
    a_flag_cause: assert property ($rose(stat.compareMatchFlag) |-> $past(matchTick))
        else $error("compare flag without match");
    a_out_enable: assert property (compareOutputEn == (cfg.outputActionSel != ACT_OFF))
        else $error("override enable wrong");
    a_off_hold: assert property (timerTick && cfg.outputActionSel == ACT_OFF |=> $stable(compareOutput))
        else $error("output moved while off");
endmodule // t8pwm_properties

bind t8pwm_top t8pwm_properties #(.DIV(DIV)) t8pwm_properties_inst (.clk_sys(clk_sys), .nrst(nrst),
    .timerRun(timerRun), .cfg(cfg), .compareWr(compareWr), .compareWrData(compareWrData),
    .compareFlagClr(compareFlagClr), .overflowFlagClr(overflowFlagClr), .stat(stat),
    .compareBufValue(compareBufValue), .timerTick(timerTick), .compareOutput(compareOutput),
    .compareOutputEn(compareOutputEn));

//--- dv/tb_top.sv
`timescale 1ns/1ps
`define CHK(nm, e, g) begin checked++; if ((g) !== (e)) begin mismatches++; \
    $display("FAIL %s exp %0h got %0h", nm, e, g); end end
module tb_top import t8pwm_pkg::*; ;
    localparam int DIV = 2;
    logic clk_sys = 1'b0, nrst = 1'b0, timerRun = 1'b0, compareWr = 1'b0;
    logic compareFlagClr = 1'b0, overflowFlagClr = 1'b0;
    t8pwm_cfg_t cfg = '{WAVE_NORMAL, ACT_OFF};
    logic [7:0] compareWrData = 8'h00, compareBufValue, c;
    t8pwm_stat_t stat;
    logic timerTick, compareOutput, compareOutputEn;
    int mismatches = 0, checked = 0, hi = 0, zc = 0;
    logic [31:0] seed = 32'h5cb6;
    t8pwm_act_t acts[4] = '{ACT_OFF, ACT_TOGGLE, ACT_CLEAR, ACT_SET};

    always #12.5 clk_sys = ~clk_sys;

    t8pwm_top #(.DIV(DIV)) t8pwm_top_inst (.clk_sys(clk_sys), .nrst(nrst), .timerRun(timerRun), .cfg(cfg),
        .compareWr(compareWr), .compareWrData(compareWrData), .compareFlagClr(compareFlagClr),
        .overflowFlagClr(overflowFlagClr), .stat(stat), .compareBufValue(compareBufValue),
        .timerTick(timerTick), .compareOutput(compareOutput), .compareOutputEn(compareOutputEn));

    function automatic logic [31:0] lfsr_next(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction

    // High ticks over one window; windows are whole periods so alignment does not matter
    function automatic int exp_high(input bit ph, input logic [1:0] a, input int cv);
        int v;
        v = ph ? 2 * cv : 2 * (cv + 1);
        if (a == 2'h0) return 0;
        if (a == 2'h1) return 256;
        return (a == 2'h2) ? v : (ph ? 510 : 512) - v;
    endfunction

    task automatic run(input int n);
        repeat (n) begin
            @(negedge clk_sys);
            while (timerTick !== 1'b1) @(negedge clk_sys);
            hi += compareOutput;
            zc += (stat.countValue == 8'h00);
        end
    endtask

    task automatic pulse(ref logic s);
        @(negedge clk_sys);
        s = 1'b1;
        @(negedge clk_sys);
        s = 1'b0;
    endtask

    task automatic wr_cmp(input logic [7:0] v);
        @(negedge clk_sys);
        compareWrData = v;
        compareWr = 1'b1;
        @(negedge clk_sys);
        compareWr = 1'b0;
    endtask

    // Fresh reset per case keeps the slope history of the checker clean
    task automatic start(input t8pwm_wave_t m, input t8pwm_act_t a, input logic [7:0] v);
        @(negedge clk_sys);
        nrst = 1'b0;
        timerRun = 1'b0;
        cfg = '{m, a};
        repeat (8) @(negedge clk_sys);
        nrst = 1'b1;
        wr_cmp(v);
        timerRun = 1'b1;
        hi = 0;
        zc = 0;
    endtask

    task final_report;
        $display("checked %0d mismatches %0d", checked, mismatches);
        if (mismatches == 0 && checked > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask

    initial begin
        int w;
        repeat (8) @(negedge clk_sys);
        nrst = 1'b1;
        @(negedge clk_sys);
        `CHK("count rst", 8'h00, stat.countValue)
        `CHK("out rst", 1'b0, compareOutput)
        for (int k = 0; k < 3; k++) begin
            seed = lfsr_next(seed);
            c = (k == 0) ? 8'h00 : {4'h0, seed[3:0]};
            start(WAVE_CLEAR, ACT_TOGGLE, c);
            `CHK("ctc cmp", c, stat.compareValue)
            w = 8 * (c + 1);
            run(w);
            `CHK("ctc high", w / 2, hi)
            `CHK("ctc wraps", 8, zc)
            `CHK("cmp flag", 1'b1, stat.compareMatchFlag)
            timerRun = 1'b0;
            pulse(compareFlagClr);
            `CHK("flag clr", 1'b0, stat.compareMatchFlag)
        end
        start(WAVE_CLEAR, ACT_TOGGLE, 8'hc8);
        run(100);
        wr_cmp(8'h32);
        run(60);
        `CHK("no ovf", 1'b0, stat.countOverflowFlag)
        `CHK("missed", 1'b1, stat.countValue > 8'h32)
        run(200);
        `CHK("ovf", 1'b1, stat.countOverflowFlag)
        timerRun = 1'b0;
        c = stat.countValue;
        pulse(overflowFlagClr);
        repeat (10) @(negedge clk_sys);
        `CHK("paused", c, stat.countValue)
        `CHK("ovf clr", 1'b0, stat.countOverflowFlag)
        for (int m = 0; m < 2; m++) begin
            for (int a = 0; a < 4; a++) begin
                for (int k = 0; k < 3; k++) begin
                    if (m == 1 && a == 1) continue;
                    seed = lfsr_next(seed);
                    c = (k == 0) ? 8'h00 : (k == 1) ? seed[7:0] : 8'hff;
                    start(m ? WAVE_PHASE : WAVE_FAST, acts[a], c);
                    `CHK("buf", c, compareBufValue)
                    `CHK("held", 8'h00, stat.compareValue)
                    `CHK("oe", a != 0, compareOutputEn)
                    run(600);
                    hi = 0;
                    zc = 0;
                    w = m ? 510 : 512;
                    run(w);
                    `CHK("high", exp_high(m, acts[a], c), hi)
                    `CHK("bottoms", m ? 1 : 2, zc)
                end
            end
        end
        final_report;
    end

    initial begin
        repeat (90000) @(posedge clk_sys);
        mismatches++;
        final_report;
    end
endmodule // tb_top

//--- rtl/t8pwm_cmp_buf.sv
`timescale 1ns/1ps
module t8pwm_cmp_buf
    import t8pwm_pkg::*;
#(
    parameter int WIDTH = COUNT_W
) (
    input wire logic clk_sys,
    input wire logic nrst,
    input wire logic wrEn,
    input wire logic [WIDTH-1:0] wrData,
    input wire logic bufferOn,
    input wire logic loadEn,
    output logic [WIDTH-1:0] activeVal,
    output logic [WIDTH-1:0] bufVal
);

    logic [WIDTH-1:0] active_ff;
    logic [WIDTH-1:0] buf_ff;
    logic [WIDTH-1:0] nxt_active;
    logic [WIDTH-1:0] nxt_buf;
    logic directWr;

    // Without buffering the write lands straight in the compared value
    assign directWr = wrEn && !bufferOn;
    assign nxt_buf = wrEn ? wrData : buf_ff;
    assign nxt_active = directWr ? wrData : ((bufferOn && loadEn) ? buf_ff : active_ff);
    assign activeVal = active_ff;
    assign bufVal = buf_ff;

    always_ff @(posedge clk_sys) begin
        if (!nrst) begin
            active_ff <= WIDTH'(COMPARE_RST);
            buf_ff <= WIDTH'(COMPARE_RST);
        end else begin
            active_ff <= nxt_active;
            buf_ff <= nxt_buf;
        end
    end

endmodule // t8pwm_cmp_buf

//--- rtl/t8pwm_pkg.sv
package t8pwm_pkg;

    localparam int COUNT_W = 8;

    localparam logic [7:0] COUNT_BOTTOM = 8'h00;
    localparam logic [7:0] COUNT_MAX = 8'hff;
    localparam logic [7:0] COUNT_ONE = 8'h01;

    localparam logic [7:0] COUNT_RST = 8'h00;
    localparam logic [7:0] COMPARE_RST = 8'h00;
    localparam logic OUTPUT_RST = 1'b0;
    localparam logic FLAG_RST = 1'b0;

    // Divide ratio of the timer clock enable; 1 steps the timer on every clock
    localparam int PRESCALE_DIV = 1;
    localparam int PRESCALE_W = 11;

    typedef enum logic [1:0] {
        WAVE_NORMAL = 2'b00,
        WAVE_PHASE = 2'b01,
        WAVE_CLEAR = 2'b10,
        WAVE_FAST = 2'b11
    } t8pwm_wave_t;

    typedef enum logic [1:0] {
        ACT_OFF = 2'b00,
        ACT_TOGGLE = 2'b01,
        ACT_CLEAR = 2'b10,
        ACT_SET = 2'b11
    } t8pwm_act_t;

    typedef enum logic {
        DIR_UP = 1'b0,
        DIR_DOWN = 1'b1
    } t8pwm_dir_t;

    localparam t8pwm_dir_t DIR_RST = DIR_UP;

    typedef struct packed {
        t8pwm_wave_t waveformModeSel;
        t8pwm_act_t outputActionSel;
    } t8pwm_cfg_t;

    typedef struct packed {
        logic [7:0] countValue;
        logic [7:0] compareValue;
        logic compareMatchFlag;
        logic countOverflowFlag;
    } t8pwm_stat_t;

endpackage

//--- rtl/t8pwm_tick_div.sv
`timescale 1ns/1ps
module t8pwm_tick_div
    import t8pwm_pkg::*;
#(
    parameter int DIV = PRESCALE_DIV,
    parameter int DIV_W = PRESCALE_W
) (
    input wire logic clk_sys,
    input wire logic nrst,
    input wire logic runEn,
    output logic tickEn
);

    localparam logic [DIV_W-1:0] LAST = DIV_W'(DIV - 1);

    logic [DIV_W-1:0] divCnt_ff;
    logic [DIV_W-1:0] nxt_divCnt;
    logic atLast;

    assign atLast = (divCnt_ff == LAST);
    assign nxt_divCnt = !runEn ? divCnt_ff : (atLast ? '0 : divCnt_ff + DIV_W'(1));
    assign tickEn = runEn && atLast;

    always_ff @(posedge clk_sys) begin
        if (!nrst) begin
            divCnt_ff <= '0;
        end else begin
            divCnt_ff <= nxt_divCnt;
        end
    end

endmodule // t8pwm_tick_div

//--- rtl/t8pwm_top.sv
`timescale 1ns/1ps
module t8pwm_top
    import t8pwm_pkg::*;
#(
    parameter int DIV = PRESCALE_DIV
) (
    input wire logic clk_sys,
    input wire logic nrst,
    input wire logic timerRun,
    input wire t8pwm_cfg_t cfg,
    input wire logic compareWr,
    input wire logic [7:0] compareWrData,
    input wire logic compareFlagClr,
    input wire logic overflowFlagClr,
    output t8pwm_stat_t stat,
    output logic [7:0] compareBufValue,
    output logic timerTick,
    output logic compareOutput,
    output logic compareOutputEn
);

    t8pwm_wave_t waveMode;
    t8pwm_act_t actMode;

    logic [7:0] count_ff;
    logic [7:0] nxt_count;
    t8pwm_dir_t dir_ff;
    t8pwm_dir_t nxt_dir;
    logic out_ff;
    logic nxt_out;
    logic matchSeen_ff;
    logic nxt_matchSeen;
    logic cmpFlag_ff;
    logic nxt_cmpFlag;
    logic ovfFlag_ff;
    logic nxt_ovfFlag;

    logic tick;
    logic [7:0] compareVal;
    logic [7:0] bufVal;

    logic isNormal;
    logic isClear;
    logic isFast;
    logic isPhase;
    logic isPwm;

    logic rawMatch;
    logic atMax;
    logic atBottom;
    logic countUp;
    logic [7:0] countInc;
    logic [7:0] countDec;

    logic [7:0] clearNext;
    logic [7:0] fastNext;
    logic [7:0] phaseNext;
    t8pwm_dir_t phaseDirNext;

    logic fastWrap;
    logic phaseTop;
    logic phaseUpNow;
    logic bufLoad;

    logic ovfClear;
    logic ovfFast;
    logic ovfPhase;
    logic ovfEvent;

    logic nonPwmOut;
    logic fastMatchOut;
    logic fastBottomLvl;
    logic fastMatchTaken;
    logic fastOut;
    logic phaseUpLvl;
    logic phaseDownLvl;
    logic phaseMatchTaken;
    logic phaseOut;
    logic modeOut;

    assign waveMode = cfg.waveformModeSel;
    assign actMode = cfg.outputActionSel;

    t8pwm_tick_div #(
        .DIV(DIV),
        .DIV_W(PRESCALE_W)
    ) u_tick_div (
        .clk_sys(clk_sys),
        .nrst(nrst),
        .runEn(timerRun),
        .tickEn(tick)
    );

    // Fast mode reloads on the wrap to bottom, phase mode at the top
    assign bufLoad = tick && ((isFast && fastWrap) || (isPhase && phaseTop));

    t8pwm_cmp_buf #(
        .WIDTH(COUNT_W)
    ) u_cmp_buf (
        .clk_sys(clk_sys),
        .nrst(nrst),
        .wrEn(compareWr),
        .wrData(compareWrData),
        .bufferOn(isPwm),
        .loadEn(bufLoad),
        .activeVal(compareVal),
        .bufVal(bufVal)
    );

    // Mode decode
    assign isNormal = (waveMode == WAVE_NORMAL);
    assign isClear = (waveMode == WAVE_CLEAR);
    assign isFast = (waveMode == WAVE_FAST);
    assign isPhase = (waveMode == WAVE_PHASE);
    assign isPwm = isFast || isPhase;

    // Comparator and count extremes
    assign rawMatch = (count_ff == compareVal);
    assign atMax = (count_ff == COUNT_MAX);
    assign atBottom = (count_ff == COUNT_BOTTOM);
    assign countUp = (dir_ff == DIR_UP);
    assign countInc = count_ff + COUNT_ONE;
    assign countDec = count_ff - COUNT_ONE;

    // Clear-on-match and normal: up count, clear on match in clear mode
    // A compare value below the count is simply passed; the wrap through max finds it again
    assign clearNext = (isClear && rawMatch) ? COUNT_BOTTOM : countInc;

    // Fast mode: plain 8-bit wrap from max to bottom
    assign fastWrap = atMax;
    assign fastNext = countInc;

    // Phase mode: max is held for exactly one step, then the slope turns
    assign phaseTop = atMax;
    assign phaseUpNow = countUp || atBottom;
    assign phaseNext = (countUp && !atMax) ? countInc :
                       (countUp && atMax) ? countDec :
                       atBottom ? countInc : countDec;
    assign phaseDirNext = (countUp && atMax) ? DIR_DOWN :
                          (!countUp && atBottom) ? DIR_UP : dir_ff;

    always_comb begin
        nxt_count = count_ff;
        nxt_dir = dir_ff;
        if (tick) begin
            case (waveMode)
                WAVE_NORMAL: begin
                    nxt_count = countInc;
                    nxt_dir = DIR_UP;
                end
                WAVE_CLEAR: begin
                    nxt_count = clearNext;
                    nxt_dir = DIR_UP;
                end
                WAVE_FAST: begin
                    nxt_count = fastNext;
                    nxt_dir = DIR_UP;
                end
                WAVE_PHASE: begin
                    nxt_count = phaseNext;
                    nxt_dir = phaseDirNext;
                end
                default: begin
                    nxt_count = count_ff;
                    nxt_dir = dir_ff;
                end
            endcase
        end
    end

    // Overflow sources per mode
    assign ovfClear = (isClear || isNormal) && atMax && (clearNext == COUNT_BOTTOM);
    assign ovfFast = isFast && atMax;
    assign ovfPhase = isPhase && !countUp && (count_ff == COUNT_ONE);
    assign ovfEvent = tick && (ovfClear || ovfFast || ovfPhase);

    // Set beats clear so an overflow landing on a software clear is kept
    assign nxt_ovfFlag = ovfEvent ? 1'b1 : (overflowFlagClr ? 1'b0 : ovfFlag_ff);

    // Match is remembered for one timer clock, then posted to the flag
    assign nxt_matchSeen = tick ? rawMatch : matchSeen_ff;
    assign nxt_cmpFlag = (tick && matchSeen_ff) ? 1'b1 :
                         (compareFlagClr ? 1'b0 : cmpFlag_ff);

    // Non-PWM actions on match: toggle, clear or set
    always_comb begin
        nonPwmOut = out_ff;
        if (rawMatch) begin
            case (actMode)
                ACT_TOGGLE: nonPwmOut = !out_ff;
                ACT_CLEAR: nonPwmOut = 1'b0;
                ACT_SET: nonPwmOut = 1'b1;
                default: nonPwmOut = out_ff;
            endcase
        end
    end

    // Fast mode: with clear or set, a match at max is ignored so that max yields a constant level
    assign fastBottomLvl = (actMode == ACT_CLEAR);
    assign fastMatchTaken = rawMatch && !(atMax && actMode[1]);
    assign fastMatchOut = (actMode == ACT_TOGGLE) ? !out_ff : !fastBottomLvl;

    always_comb begin
        fastOut = out_ff;
        case (actMode)
            ACT_TOGGLE: fastOut = rawMatch ? !out_ff : out_ff;
            ACT_CLEAR, ACT_SET: begin
                if (fastWrap) begin
                    fastOut = fastBottomLvl;
                end else if (fastMatchTaken) begin
                    fastOut = fastMatchOut;
                end
            end
            default: fastOut = out_ff;
        endcase
    end

    // Phase mode: the up-slope match level, and its opposite on the down slope
    assign phaseUpLvl = (actMode == ACT_SET);
    assign phaseDownLvl = !phaseUpLvl;
    assign phaseMatchTaken = rawMatch && !atMax;

    always_comb begin
        phaseOut = out_ff;
        case (actMode)
            ACT_CLEAR, ACT_SET: begin
                if (phaseTop) begin
                    // At top the level is forced from the value being loaded, which catches
                    // a missed up match and a compare value leaving max alike
                    phaseOut = (bufVal == COUNT_MAX) ? phaseDownLvl : phaseUpLvl;
                end else if (phaseMatchTaken) begin
                    phaseOut = phaseUpNow ? phaseUpLvl : phaseDownLvl;
                end
            end
            default: phaseOut = out_ff;
        endcase
    end

    always_comb begin
        modeOut = out_ff;
        case (waveMode)
            WAVE_NORMAL: modeOut = nonPwmOut;
            WAVE_CLEAR: modeOut = nonPwmOut;
            WAVE_FAST: modeOut = fastOut;
            WAVE_PHASE: modeOut = phaseOut;
            default: modeOut = out_ff;
        endcase
    end

    assign nxt_out = tick ? modeOut : out_ff;

    always_ff @(posedge clk_sys) begin
        if (!nrst) begin
            count_ff <= COUNT_RST;
            dir_ff <= DIR_RST;
        end else begin
            count_ff <= nxt_count;
            dir_ff <= nxt_dir;
        end
    end

    always_ff @(posedge clk_sys) begin
        if (!nrst) begin
            out_ff <= OUTPUT_RST;
            matchSeen_ff <= FLAG_RST;
        end else begin
            out_ff <= nxt_out;
            matchSeen_ff <= nxt_matchSeen;
        end
    end

    always_ff @(posedge clk_sys) begin
        if (!nrst) begin
            cmpFlag_ff <= FLAG_RST;
            ovfFlag_ff <= FLAG_RST;
        end else begin
            cmpFlag_ff <= nxt_cmpFlag;
            ovfFlag_ff <= nxt_ovfFlag;
        end
    end

    assign stat.countValue = count_ff;
    assign stat.compareValue = compareVal;
    assign stat.compareMatchFlag = cmpFlag_ff;
    assign stat.countOverflowFlag = ovfFlag_ff;
    assign compareBufValue = bufVal;
    assign timerTick = tick;
    assign compareOutput = out_ff;

    // Only the port override; the pin driver itself stays under the port direction bit
    assign compareOutputEn = (actMode != ACT_OFF);

endmodule // t8pwm_top
